// ==== src/i2cs_params.svh ====
// Constants of the two-wire register access slave: addresses, bit counts, limits.
// Assumes inclusion by the package and the top module; guarded against double inclusion.
`ifndef I2CS_PARAMS_SVH
`define I2CS_PARAMS_SVH

// Seven-bit slave addresses of the three register blocks
`define I2CS_ADR_MAIN   7'h28
`define I2CS_ADR_FG     7'h36
`define I2CS_ADR_RAM    7'h40

// Addresses that must never be answered
`define I2CS_ADR_GCALL  7'h00
`define I2CS_ADR_DEVID  7'h7C

// Upper five bits of the high-speed master code
`define I2CS_HS_CODE    5'h01

// Bit slot numbers within one nine-clock packet
`define I2CS_LAST_BIT   4'h7
`define I2CS_ACK_BIT    4'h8

// Last fuel-gauge word address, RAM size
`define I2CS_FG_LAST    8'hFF
`define I2CS_RAM_BYTES  128
`define I2CS_RAM_AW     7

`endif

// ==== src/i2cs_pkg.sv ====
// Types shared by the register access slave: phases, banks, state records.
// Assumes the constants header sits beside it in the include path.
package i2cs_pkg;
`include "i2cs_params.svh"

	typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_PTR, PH_WR, PH_RD} phase_t;
	typedef enum logic [1:0] {BK_MAIN, BK_FG, BK_RAM} bank_t;
	typedef enum logic [1:0] {SS_IDLE, SS_ISSUE, SS_WAIT} sys_state_t;

	// Everything clocked by the link clock, apart from the mailbox RAM
	typedef struct packed {
		logic        rs1;
		logic        rs2;
		logic        scl1;
		logic        scl2;
		logic        scl3;
		logic        sda1;
		logic        sda2;
		logic        sda3;
		phase_t      phase;
		logic [3:0]  cnt;
		logic [7:0]  sh;
		logic        rw;
		bank_t       bank;
		logic [7:0]  ptr;
		logic        hi;
		logic [7:0]  lo;
		logic        ovf;
		logic        hs;
		logic        oe;
		logic        sdo;
		logic [7:0]  tx;
		logic        pend;
		logic        pend_wr;
		logic [7:0]  cm_addr;
		bank_t       cm_bank;
		logic [15:0] cm_data;
		logic        rq_tgl;
		logic [7:0]  rq_addr;
		bank_t       rq_bank;
		logic [15:0] rq_data;
		logic        rq_wr;
		logic        ack1;
		logic        ack2;
	} link_state_t;

	// Everything clocked by the system clock
	typedef struct packed {
		logic        rq1;
		logic        rq2;
		logic        rq3;
		sys_state_t  st;
		logic [7:0]  addr;
		bank_t       bank;
		logic [15:0] wdata;
		logic        wr;
		logic        ack_tgl;
		logic [15:0] rdat;
		logic        acc_wr;
		logic        acc_rd;
		logic        hs1;
		logic        hs2;
	} sys_regs_t;
endpackage

// ==== src/i2cs_ram.sv ====
// Byte-wide mailbox storage with one write port and a registered read port.
// Assumes both ports run on the link clock of the slave.
`timescale 1ns/1ps
module i2cs_ram #(
	parameter int DEPTH = 128,
	parameter int AW    = 7,
	parameter int DW    = 8
) (
	input  wire logic          i_clk,
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_waddr,
	input  wire logic [DW-1:0] i_wdata,
	input  wire logic [AW-1:0] i_raddr,
	output logic      [DW-1:0] o_rdata
);
	typedef struct packed {
		logic [DEPTH-1:0][DW-1:0] mem;
		logic [DW-1:0]            rdata;
	} ram_state_t;

	ram_state_t ram_ff;
	ram_state_t nxt_ram;

	////////////////////////////////////////////////////////////////////////
	// Read first: a write in the same clock is not seen; read data lags the address by one clock
	always_comb begin
		nxt_ram = ram_ff;
		nxt_ram.rdata = ram_ff.mem[i_raddr];
		if (i_we) begin
			nxt_ram.mem[i_waddr] = i_wdata;
		end
	end

	// No reset: contents are undefined until written, like any RAM
	always_ff @(posedge i_clk) begin
		ram_ff <= nxt_ram;
	end

	assign o_rdata = ram_ff.rdata;
endmodule

// ==== src/i2cs_top.sv ====
// Two-wire register access slave: three slave addresses, byte and word banks, mailbox RAM.
// Assumes SCL and SDA are open-drain pins from an outside master; chip registers sit on the
// system clock behind the o_acc_* request group; the link clock is free running.
//
// Functional notes
// - Never hold the clock line low; no clock stretching anywhere.
// - Ignore the all-zeros general call address; no acknowledge.
// - No answer to the device-identification query.
// - Work at any serial clock rate up to 400kHz.
// - Power-up and every stop select the filters for 1MHz and below.
// - Repeated start keeps filter mode; stop restores slow filter mode.
// - Transfer opens with 7-bit address plus direction; addressed slave acknowledges.
// - Write: address, 8-bit pointer acknowledged, data byte, then stop or Sr.
// - Written byte commits on next rising data-line edge after acknowledge.
// - Sequential write continues over successive registers, each byte acknowledged.
// - Accept acknowledge or not-acknowledge in last write acknowledge slot.
// - Fuel-gauge words take one address byte, then low byte, high byte.
// - Word address increments after the last bit of every word; in a read it steps only when the master acknowledges the word's last byte.
// - Word writes beyond address FFh are dropped.
// - Writes to read-only word addresses are ignored.
// - Read: pointer, Sr, read address; device sends eight bits MSB first.
// - Master acknowledges for more, not-acknowledges the final byte.
// - Stop leaves the register pointer untouched.
// - Three slave addresses: byte registers, fuel-gauge words, RAM.
// - RAM block holds 128 bytes.
// - Acknowledge every pointer value, existing register or not.
`timescale 1ns/1ps
`include "i2cs_params.svh"
module i2cs_top
	import i2cs_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_b,
	input  wire logic        i_clk_link,
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output logic             o_sda_out,
	output logic             o_sda_oe,
	output logic [7:0]       o_acc_addr,
	output bank_t            o_acc_bank,
	output logic [15:0]      o_acc_wdata,
	output logic             o_acc_wr,
	output logic             o_acc_rd,
	input  wire logic [15:0] i_acc_rdata,
	input  wire logic        i_acc_ro,
	output logic             o_filter_hs
);
	link_state_t l_ff;
	link_state_t nxt_l;
	sys_regs_t   s_ff;
	sys_regs_t   nxt_s;

	logic        scl_rise;
	logic        scl_fall;
	logic        sda_rise;
	logic        ev_start;
	logic        ev_stop;
	logic        busy;
	logic        mem_we;
	logic [7:0]  mem_rdata;
	logic [7:0]  rd_byte;

	////////////////////////////////////////////////////////////////////////
	// Bus events from the synchronised pins; the first stage is never looked at
	assign scl_rise = l_ff.scl2 & ~l_ff.scl3;
	assign scl_fall = ~l_ff.scl2 & l_ff.scl3;
	assign sda_rise = l_ff.sda2 & ~l_ff.sda3;
	assign ev_start = ~l_ff.sda2 & l_ff.sda3 & l_ff.scl2 & l_ff.scl3;
	assign ev_stop  = sda_rise & l_ff.scl2 & l_ff.scl3;
	assign busy     = l_ff.rq_tgl ^ l_ff.ack2;

	// Byte to send: RAM from storage, zero past its end; the rest from the last fetched word
	always_comb begin
		if (l_ff.bank == BK_RAM) begin
			rd_byte = l_ff.ptr[7] ? '0 : mem_rdata;
		end else if (l_ff.bank == BK_FG && l_ff.hi) begin
			rd_byte = s_ff.rdat[15:8];
		end else begin
			rd_byte = s_ff.rdat[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link side protocol engine
	always_comb begin
		nxt_l = l_ff;
		mem_we = 1'b0;
		{nxt_l.rs2, nxt_l.rs1} = {l_ff.rs1, i_rst_b};
		{nxt_l.scl3, nxt_l.scl2, nxt_l.scl1} = {l_ff.scl2, l_ff.scl1, i_scl};
		{nxt_l.sda3, nxt_l.sda2, nxt_l.sda1} = {l_ff.sda2, l_ff.sda1, i_sda};
		{nxt_l.ack2, nxt_l.ack1} = {l_ff.ack1, s_ff.ack_tgl};
		// Pending commit or fetch; a write waits for the data line to rise or for a start
		if (l_ff.pend && (!l_ff.pend_wr || sda_rise || ev_start)) begin
			if (l_ff.cm_bank == BK_RAM) begin
				nxt_l.pend = 1'b0;
				mem_we = 1'b1;
			end else if (!busy) begin
				nxt_l.pend = 1'b0;
				nxt_l.rq_tgl = ~l_ff.rq_tgl;
				nxt_l.rq_addr = l_ff.cm_addr;
				nxt_l.rq_bank = l_ff.cm_bank;
				nxt_l.rq_data = l_ff.cm_data;
				nxt_l.rq_wr = l_ff.pend_wr;
			end
		end
		if (ev_start) begin
			// Repeated start keeps the filter mode
			nxt_l.phase = PH_ADDR;
			nxt_l.cnt = 4'hF; // The start's own clock fall wraps this to bit zero
			nxt_l.oe = 1'b0;
		end else if (ev_stop) begin
			// Pointer deliberately kept across a stop
			nxt_l.phase = PH_IDLE;
			nxt_l.oe = 1'b0;
			nxt_l.hs = 1'b0;
		end else if (l_ff.phase != PH_IDLE && scl_rise) begin
			if (l_ff.cnt != `I2CS_ACK_BIT) begin
				nxt_l.sh = {l_ff.sh[6:0], l_ff.sda2};
			end else if (l_ff.phase == PH_RD) begin
				if (l_ff.sda2) begin
					// Not-acknowledge ends the read; wait for stop or Sr
					nxt_l.phase = PH_IDLE;
				end else if (l_ff.bank == BK_FG && !l_ff.hi) begin
					nxt_l.hi = 1'b1;
				end else begin
					nxt_l.hi = 1'b0;
					nxt_l.ptr = l_ff.ptr + 8'h01;
					nxt_l.pend = l_ff.bank != BK_RAM;
					nxt_l.pend_wr = 1'b0;
					nxt_l.cm_addr = l_ff.ptr + 8'h01;
					nxt_l.cm_bank = l_ff.bank;
				end
			end
		end else if (l_ff.phase != PH_IDLE && scl_fall) begin
			if (l_ff.cnt == `I2CS_LAST_BIT) begin
				nxt_l.cnt = `I2CS_ACK_BIT;
				nxt_l.oe = 1'b1;
				case (l_ff.phase)
					PH_ADDR: begin
						nxt_l.rw = l_ff.sh[0];
						nxt_l.pend = 1'b0;
						nxt_l.pend_wr = 1'b0;
						nxt_l.cm_addr = l_ff.ptr;
						if (l_ff.sh[7:1] == `I2CS_ADR_MAIN) begin
							nxt_l.bank = BK_MAIN;
							nxt_l.pend = l_ff.sh[0];
							nxt_l.cm_bank = BK_MAIN;
						end else if (l_ff.sh[7:1] == `I2CS_ADR_FG) begin
							nxt_l.bank = BK_FG;
							nxt_l.pend = l_ff.sh[0];
							nxt_l.cm_bank = BK_FG;
						end else if (l_ff.sh[7:1] == `I2CS_ADR_RAM) begin
							nxt_l.bank = BK_RAM;
						end else begin
							// General call, identity query and others get no answer
							nxt_l.oe = 1'b0;
							nxt_l.phase = PH_IDLE;
							// High-speed master code switches the filters until stop
							if (l_ff.sh[7:3] == `I2CS_HS_CODE) begin
								nxt_l.hs = 1'b1;
							end
						end
					end
					PH_PTR: begin
						// Every pointer value is acknowledged
						nxt_l.ptr = l_ff.sh;
						nxt_l.hi = 1'b0;
						nxt_l.ovf = 1'b0;
					end
					PH_WR: begin
						nxt_l.cm_addr = l_ff.ptr;
						nxt_l.cm_bank = l_ff.bank;
						nxt_l.cm_data = {8'h00, l_ff.sh};
						nxt_l.pend_wr = 1'b1;
						if (l_ff.bank == BK_FG) begin
							nxt_l.hi = ~l_ff.hi;
							if (!l_ff.hi) begin
								nxt_l.lo = l_ff.sh;
							end else begin
								// Step after the last bit of each word
								nxt_l.cm_data = {l_ff.sh, l_ff.lo};
								nxt_l.pend = ~l_ff.ovf;
								nxt_l.ovf = l_ff.ovf | (l_ff.ptr == `I2CS_FG_LAST);
								nxt_l.ptr = l_ff.ptr + 8'h01;
							end
						end else begin
							// RAM beyond its size is acknowledged but not stored
							nxt_l.pend = (l_ff.bank != BK_RAM) | ~l_ff.ptr[7];
							nxt_l.ptr = l_ff.ptr + 8'h01;
						end
					end
					default: begin
						// Reading: let go so the master can answer
						nxt_l.oe = 1'b0;
					end
				endcase
			end else if (l_ff.cnt == `I2CS_ACK_BIT) begin
				nxt_l.cnt = '0;
				nxt_l.oe = 1'b0;
				// Acknowledge slot of written bytes is never sampled
				case (l_ff.phase)
					PH_ADDR: begin
						nxt_l.phase = l_ff.rw ? PH_RD : PH_PTR;
						if (l_ff.rw) begin
							nxt_l.tx = rd_byte;
							nxt_l.oe = ~rd_byte[7];
						end
					end
					PH_PTR: begin
						nxt_l.phase = PH_WR;
					end
					PH_RD: begin
						nxt_l.tx = rd_byte;
						nxt_l.oe = ~rd_byte[7];
					end
					default: begin
						nxt_l.phase = l_ff.phase;
					end
				endcase
			end else begin
				nxt_l.cnt = l_ff.cnt + 4'h1;
				if (l_ff.phase == PH_RD) begin
					// MSB already out; shift the next bit up
					nxt_l.tx = {l_ff.tx[6:0], 1'b0};
					nxt_l.oe = ~l_ff.tx[6];
				end
			end
		end
		// Link reset is the system reset after a two-stage resync
		if (!l_ff.rs2) begin
			nxt_l = '0;
			nxt_l.rs1 = i_rst_b;
			nxt_l.rs2 = l_ff.rs1;
			{nxt_l.scl1, nxt_l.scl2, nxt_l.scl3, nxt_l.sda1, nxt_l.sda2, nxt_l.sda3} = '1;
		end
	end

	// SCL is input only: nothing here can pull it low
	always_ff @(posedge i_clk_link) begin
		l_ff <= nxt_l;
	end

	i2cs_ram #(
		.DEPTH (`I2CS_RAM_BYTES),
		.AW    (`I2CS_RAM_AW),
		.DW    (8)
	) u_ram (
		.i_clk   (i_clk_link),
		.i_we    (mem_we),
		.i_waddr (l_ff.cm_addr[6:0]),
		.i_wdata (l_ff.cm_data[7:0]),
		.i_raddr (l_ff.ptr[6:0]),
		.o_rdata (mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// System side: toggle handshake, one chip access per request, none for a write to a read-only word
	always_comb begin
		nxt_s = s_ff;
		nxt_s.rq1 = l_ff.rq_tgl;
		nxt_s.rq2 = s_ff.rq1;
		nxt_s.rq3 = s_ff.rq2;
		nxt_s.hs1 = l_ff.hs;
		nxt_s.hs2 = s_ff.hs1;
		nxt_s.acc_wr = 1'b0;
		nxt_s.acc_rd = 1'b0;
		case (s_ff.st)
			SS_IDLE: begin
				// Request words stay still until acknowledged, so a plain capture is safe
				if (s_ff.rq2 ^ s_ff.rq3) begin
					nxt_s.addr = l_ff.rq_addr;
					nxt_s.bank = l_ff.rq_bank;
					nxt_s.wdata = l_ff.rq_data;
					nxt_s.wr = l_ff.rq_wr;
					nxt_s.st = SS_ISSUE;
				end
			end
			SS_ISSUE: begin
				if (s_ff.wr) begin
					nxt_s.acc_wr = ~(s_ff.bank == BK_FG && i_acc_ro);
					nxt_s.ack_tgl = ~s_ff.ack_tgl;
					nxt_s.st = SS_IDLE;
				end else begin
					nxt_s.acc_rd = 1'b1;
					nxt_s.st = SS_WAIT;
				end
			end
			SS_WAIT: begin
				nxt_s.rdat = i_acc_rdata;
				nxt_s.ack_tgl = ~s_ff.ack_tgl;
				nxt_s.st = SS_IDLE;
			end
			default: begin
				nxt_s.st = SS_IDLE;
			end
		endcase
		if (!i_rst_b) begin
			nxt_s = '0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		s_ff <= nxt_s;
	end

	// All outputs straight from flops
	assign o_sda_out   = l_ff.sdo;
	assign o_sda_oe    = l_ff.oe;
	assign o_acc_addr  = s_ff.addr;
	assign o_acc_bank  = s_ff.bank;
	assign o_acc_wdata = s_ff.wdata;
	assign o_acc_wr    = s_ff.acc_wr;
	assign o_acc_rd    = s_ff.acc_rd;
	assign o_filter_hs = s_ff.hs2;

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_gcall_no_ack: assert property (@(posedge i_clk_link) disable iff (!l_ff.rs2)
		(scl_fall && l_ff.phase == PH_ADDR && l_ff.cnt == `I2CS_LAST_BIT && l_ff.sh[7:1] == `I2CS_ADR_GCALL)
		|=> !l_ff.oe ##1 !l_ff.oe) else $error("general call address acknowledged");
	a_devid_no_ack: assert property (@(posedge i_clk_link) disable iff (!l_ff.rs2)
		(scl_fall && l_ff.phase == PH_ADDR && l_ff.cnt == `I2CS_LAST_BIT && l_ff.sh[7:1] == `I2CS_ADR_DEVID)
		|=> !l_ff.oe && l_ff.phase == PH_IDLE) else $error("identity query acknowledged");
	a_ptr_acked: assert property (@(posedge i_clk_link) disable iff (!l_ff.rs2)
		(scl_fall && l_ff.phase == PH_PTR && l_ff.cnt == `I2CS_LAST_BIT)
		|=> l_ff.oe && l_ff.cnt == `I2CS_ACK_BIT && l_ff.ptr == $past(l_ff.sh)) else $error("pointer byte not acknowledged");
	a_stop_filter: assert property (@(posedge i_clk_link) disable iff (!l_ff.rs2)
		ev_stop |=> !l_ff.hs ##1 !l_ff.hs) else $error("stop did not restore filter mode");
	a_sr_filter: assert property (@(posedge i_clk_link) disable iff (!l_ff.rs2)
		ev_start |=> l_ff.hs == $past(l_ff.hs)) else $error("repeated start changed filter mode");
	a_commit_rise: assert property (@(posedge i_clk_link) disable iff (!l_ff.rs2)
		(l_ff.pend && l_ff.pend_wr && l_ff.cm_bank != BK_RAM && !busy && sda_rise)
		|=> l_ff.rq_tgl != $past(l_ff.rq_tgl) && l_ff.rq_wr && !l_ff.pend) else $error("write not committed");
	a_word_step: assert property (@(posedge i_clk_link) disable iff (!l_ff.rs2)
		(scl_fall && l_ff.phase == PH_WR && l_ff.cnt == `I2CS_LAST_BIT && l_ff.bank == BK_FG && l_ff.hi)
		|=> l_ff.ptr == $past(l_ff.ptr) + 8'h01 && !l_ff.hi) else $error("word address did not step");
	a_word_drop: assert property (@(posedge i_clk_link) disable iff (!l_ff.rs2)
		(scl_fall && l_ff.phase == PH_WR && l_ff.cnt == `I2CS_LAST_BIT && l_ff.bank == BK_FG
		&& l_ff.hi && l_ff.ovf && !l_ff.pend) |=> !l_ff.pend) else $error("word past last address kept");
	a_ptr_stop: assert property (@(posedge i_clk_link) disable iff (!l_ff.rs2)
		ev_stop |=> $stable(l_ff.ptr)) else $error("stop changed the pointer");
	a_ro_block: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(s_ff.st == SS_ISSUE && s_ff.wr && s_ff.bank == BK_FG && i_acc_ro) |=> !o_acc_wr) else $error("read-only word written");
	c_byte_write: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) o_acc_wr && o_acc_bank == BK_MAIN);
	c_word_read: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) o_acc_rd && o_acc_bank == BK_FG);
	c_hs_mode: cover property (@(posedge i_clk_link) disable iff (!l_ff.rs2) l_ff.hs && ev_start);
	c_ram_write: cover property (@(posedge i_clk_link) disable iff (!l_ff.rs2) mem_we);
endmodule

// ==== test/i2cs_master_model.sv ====
// Behavioural two-wire bus master: start, stop, byte out, byte in.
// Assumes the bench builds the open-drain data wire with a pull-up.
`timescale 1ns/1ps
module i2cs_master_model (
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_low
);
	// Clock low is 1.4 us, inside the 400 kHz limit, so slow fetches still fit
	localparam time T_LO = 700;
	localparam time T_HI = 800;

	////////////////////////////////////////////////////////////////////////////
	// Idle bus: both lines released, clock stands high between frames
	initial begin
		o_scl     = 1'b1;
		o_sda_low = 1'b0;
	end

	// One clock: data set while low, sampled while high
	task automatic bit_io(input logic b, output logic r);
		o_sda_low = ~b;
		#T_LO;
		o_scl = 1'b1;
		#T_HI;
		r = i_sda;
		o_scl = 1'b0;
		#T_LO;
	endtask

	// Start or repeated start: data falls while clock is high
	task automatic start();
		o_sda_low = 1'b0;
		#T_LO;
		o_scl = 1'b1;
		#T_HI;
		o_sda_low = 1'b1;
		#T_HI;
		o_scl = 1'b0;
		#T_LO;
	endtask

	// Stop: data rises while clock is high, then bus left released
	task automatic stop();
		o_sda_low = 1'b1;
		#T_LO;
		o_scl = 1'b1;
		#T_HI;
		o_sda_low = 1'b0;
		#T_HI;
	endtask

	// Byte MSB first, returns the device acknowledge
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	// Byte in; acknowledge to ask for more, release on the last
	task automatic get_byte(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(~mack, r);
	endtask
endmodule

// ==== test/i2c_slave_register_access_tb.sv ====
// Self-checking bench of the register access slave with a bus master model.
// Assumes the chip side answers reads from the address and flags word 0x10 read-only.
`timescale 1ns/1ps
`include "i2cs_params.svh"
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin num_errors++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module i2c_slave_register_access_tb
	import i2cs_pkg::*;
;
	localparam logic [7:0] RO_WORD = 8'h10;
	logic        clk_sys, rst_b, clk_link, scl, sda_low, sda_out, sda_oe;
	logic        acc_wr, acc_rd, acc_ro, filter_hs, ack;
	logic [7:0]  acc_addr, d0, d1;
	bank_t       acc_bank;
	logic [15:0] acc_wdata, acc_rdata;
	logic [25:0] exp_q[$];
	logic [25:0] e;
	logic [6:0]  bad[3] = '{`I2CS_ADR_GCALL, `I2CS_ADR_DEVID, 7'h29};
	int          num_errors, checks, seed, num_reads;
	wire         sda = ~(sda_low | sda_oe);

	////////////////////////////////////////////////////////////////////////////
	// Clocks, the link one unrelated in phase
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		clk_link = 1'b0;
		#3.7;
		forever #6 clk_link = ~clk_link;
	end

	// Chip side: read data follows the address, so it is valid while a read pulses
	assign acc_rdata = {acc_addr ^ 8'hA5, ~acc_addr};
	assign acc_ro    = (acc_bank == BK_FG) && (acc_addr == RO_WORD);

	i2cs_top i_dut (.i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_clk_link(clk_link), .i_scl(scl),
		.i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_acc_addr(acc_addr),
		.o_acc_bank(acc_bank), .o_acc_wdata(acc_wdata), .o_acc_wr(acc_wr), .o_acc_rd(acc_rd),
		.i_acc_rdata(acc_rdata), .i_acc_ro(acc_ro), .o_filter_hs(filter_hs));
	// Clock line is an input only, so the device cannot stretch it
	i2cs_master_model i_mst (.i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

	////////////////////////////////////////////////////////////////////////////
	// Every chip write is matched against the oldest note; chip reads are counted
	always @(posedge clk_sys) begin
		if (acc_rd === 1'b1) begin
			num_reads++;
		end
		if (acc_wr === 1'b1) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 26'h3FFFFFF;
			`CHK("chip write", e, {acc_addr, acc_bank, acc_wdata})
		end
	end

	task automatic addr(input logic [6:0] a, input logic r, input logic ex);
		logic k;
		i_mst.put_byte({a, r}, k);
		`CHK("address ack", ex, k)
	endtask

	task automatic wr(input logic [7:0] d);
		logic k;
		i_mst.put_byte(d, k);
		`CHK("byte ack", 1'b1, k)
	endtask

	task automatic rd(input logic mack, input logic [7:0] ex);
		logic [7:0] d;
		i_mst.get_byte(mack, d);
		`CHK("read byte", ex, d)
	endtask

	// Lets the chip side drain, then nothing noted may be left over
	task automatic settle();
		repeat (40) @(posedge clk_sys);
		`CHK("writes left", 0, exp_q.size())
		`CHK("data out level", 1'b0, sda_out)
	endtask

	// Two words from address a; the second lands only when two is set
	task automatic fg_pair(input logic [7:0] a, input logic two);
		logic [7:0] w[4];
		foreach (w[i]) w[i] = 8'($random(seed));
		exp_q.push_back({a, BK_FG, w[1], w[0]});
		if (two) exp_q.push_back({a + 8'h01, BK_FG, w[3], w[2]});
		i_mst.start();
		addr(`I2CS_ADR_FG, 1'b0, 1'b1);
		wr(a);
		foreach (w[i]) wr(w[i]);
		i_mst.stop();
		settle();
	endtask

	task automatic give_verdict();
		if (num_errors == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Cuts a hang short; the run needs some 10400 system cycles
	initial begin
		repeat (40000) @(posedge clk_sys);
		num_errors++;
		give_verdict();
	end

	// Pointers are chosen to reach the read-only word and the ends of the ranges
	initial begin
		seed = 73;
		rst_b = 1'b0;
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		`CHK("filter after reset", 1'b0, filter_hs)
		repeat (3) @(posedge clk_sys);
		// Sequential byte write at the top of the pointer range
		d0 = 8'($random(seed));
		d1 = 8'($random(seed));
		exp_q.push_back({8'hFE, BK_MAIN, 8'h00, d0});
		exp_q.push_back({8'hFF, BK_MAIN, 8'h00, d1});
		i_mst.start();
		addr(`I2CS_ADR_MAIN, 1'b0, 1'b1);
		wr(8'hFE);
		wr(d0);
		wr(d1);
		i_mst.stop();
		settle();
		// Refused addresses get no acknowledge and write nothing
		foreach (bad[i]) begin
			i_mst.start();
			addr(bad[i], 1'b0, 1'b0);
			i_mst.stop();
		end
		settle();
		fg_pair(8'h0E, 1'b1);
		fg_pair(8'h0F, 1'b0);
		fg_pair(8'hFF, 1'b0);
		// Byte read with pointer, then again without one after a stop
		i_mst.start();
		addr(`I2CS_ADR_MAIN, 1'b0, 1'b1);
		wr(8'hF3);
		i_mst.start();
		addr(`I2CS_ADR_MAIN, 1'b1, 1'b1);
		rd(1'b1, 8'h0C);
		rd(1'b0, 8'h0B);
		i_mst.stop();
		i_mst.start();
		addr(`I2CS_ADR_MAIN, 1'b1, 1'b1);
		rd(1'b0, 8'h0B);
		i_mst.stop();
		// Word read: low byte, then high byte
		i_mst.start();
		addr(`I2CS_ADR_FG, 1'b0, 1'b1);
		wr(8'h20);
		i_mst.start();
		addr(`I2CS_ADR_FG, 1'b1, 1'b1);
		rd(1'b1, 8'hDF);
		rd(1'b0, 8'h85);
		i_mst.stop();
		// Mailbox: last byte kept, the one past the end dropped, chip side untouched
		i_mst.start();
		addr(`I2CS_ADR_RAM, 1'b0, 1'b1);
		wr(8'h7F);
		wr(d1);
		wr(d0);
		i_mst.stop();
		i_mst.start();
		addr(`I2CS_ADR_RAM, 1'b0, 1'b1);
		wr(8'h7F);
		i_mst.start();
		addr(`I2CS_ADR_RAM, 1'b1, 1'b1);
		rd(1'b1, d1);
		rd(1'b0, 8'h00);
		i_mst.stop();
		settle();
		// Master code first switches the filters
		i_mst.start();
		i_mst.put_byte(8'h08, ack);
		`CHK("code ack", 1'b0, ack)
		repeat (10) @(posedge clk_sys);
		`CHK("filter fast", 1'b1, filter_hs)
		i_mst.start();
		repeat (10) @(posedge clk_sys);
		`CHK("filter after Sr", 1'b1, filter_hs)
		i_mst.stop();
		repeat (10) @(posedge clk_sys);
		`CHK("filter after stop", 1'b0, filter_hs)
		settle();
		// One fetch per byte or word shown: two plus one byte reads, one word read
		`CHK("chip reads", 4, num_reads)
		give_verdict();
	end
endmodule
